// *** src/smseq_pkg.sv ***
// Package of constants and types for the strain measurement sequencer.
package smseq_pkg;

   // -----------------------------------------------------------------
   // Field widths and formats
   // -----------------------------------------------------------------
   localparam int RESULT_W = 24;
   localparam int RESULT_FRAC = 8;
   localparam int GAIN_W = 24;
   localparam int GAIN_FRAC = 16;
   localparam int TIME_W = 16;
   localparam int TEMP_W = 16;
   localparam int TEMP_FRAC = 14;
   localparam int CORR_W = 24;
   localparam logic [7:0] OPC_INIT = 8'hC0;

   // -----------------------------------------------------------------
   // Configuration positions and reset values
   // -----------------------------------------------------------------
   localparam int CFG0_CALAVG_HI = 23;
   localparam int CFG0_CALAVG_LO = 22;
   localparam int CFG0_SIMPLE = 21;
   localparam logic [3:0] CAL_DELAY_DEF = 4'h4;
   localparam logic [3:0] CAL_DELAY_OFS = 4'h3;
   localparam logic [3:0] CAL_INTERVAL_DEF = 4'h3;
   localparam logic [1:0] CAL_AVG_DEF = 2'h2;
   localparam logic [3:0] CAL_MEAS_CYC = 4'h4;
   localparam logic [2:0] ADAPT_DEF = 3'h4;

   // -----------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      SM_WAIT, SM_SWITCH_A, SM_SWITCH_B, SM_SWITCH_AB, SM_TEMP_SENSE, SM_TEMP_REF, SM_FORMAT, SM_DONE
   } smseq_state_t;

endpackage : smseq_pkg

// *** src/smseq_cal_timer.sv ***
// Calibration timer of the high speed time converter unit.
module smseq_cal_timer
   import smseq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dischargeStart,
   input wire logic [3:0] calibrationStartDelay,
   input wire logic calEnable,
   output logic calActive,
   output logic calDone
);

   logic [4:0] cnt_r, cnt_nxt;
   logic run_r, run_nxt;
   logic done_r, done_nxt;
   logic [4:0] startAt;
   logic [4:0] endAt;

   // -----------------------------------------------------------------
   // Delay counter
   // -----------------------------------------------------------------
   // delay plus three
   assign startAt = {1'b0, calibrationStartDelay} + {1'b0, CAL_DELAY_OFS};
   assign endAt = startAt + {1'b0, CAL_MEAS_CYC};

   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      done_nxt = 1'b0;
      if (dischargeStart && calEnable && calibrationStartDelay != 4'h0) begin
         run_nxt = 1'b1;
         cnt_nxt = 5'h01;
      end else if (run_r) begin
         cnt_nxt = cnt_r + 5'h01;
         if (cnt_nxt == endAt) begin
            run_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 5'h00;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         done_r <= done_nxt;
      end
   end

   assign calActive = run_r && cnt_r >= startAt;
   assign calDone = done_r;

endmodule : smseq_cal_timer

// *** src/strain_measurement_sequencing.sv ***
// Measurement sequencer and result formatting for the strain front end.
module strain_measurement_sequencing
   import smseq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic startPulse,
   input wire logic commandStrobe,
   input wire logic [7:0] commandCode,
   input wire logic serialAccess,
   input wire logic oneShotSelect,
   input wire logic measRangeTwo,
   input wire logic tempEnable,
   input wire logic [GAIN_W-1:0] firstGainFactor,
   input wire logic [GAIN_W-1:0] secondGainFactor,
   input wire logic firstGainPolarity,
   input wire logic secondGainPolarity,
   input wire logic secondGainEnable,
   input wire logic [3:0] calibrationStartDelay,
   input wire logic [3:0] calibrationInterval,
   input wire logic [1:0] calibrationAveraging,
   input wire logic [3:0] switchCorrectionAveraging,
   input wire logic [2:0] switchCorrectionAdaptSpeed,
   input wire logic simplifiedSwitchCompensation,
   input wire logic storedCorrectionLoad,
   input wire logic [CORR_W-1:0] storedSwitchCorrectionA,
   input wire logic [CORR_W-1:0] storedSwitchCorrectionB,
   input wire logic timeValid,
   input wire logic [TIME_W-1:0] timeValue,
   output logic dischargeStart,
   output logic [2:0] dischargePath,
   output logic calActive,
   output logic [6:0] calAverageCount,
   output logic [RESULT_W-1:0] bridgeOneResult,
   output logic [RESULT_W-1:0] bridgeTwoResult,
   output logic [TEMP_W-1:0] tempRatio,
   output logic [CORR_W-1:0] switchCorrectionA,
   output logic [CORR_W-1:0] switchCorrectionB,
   output logic busy,
   output logic dataReady_n
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Signed product of a time difference and a gain, rescaled to 16.8.
   function automatic logic [RESULT_W-1:0] applyGain(input logic signed [TIME_W:0] diff,
                                                     input logic [GAIN_W-1:0] gain,
                                                     input logic neg);
      logic signed [TIME_W+GAIN_W+1:0] prod;
      logic signed [TIME_W+GAIN_W+1:0] sgn;
      prod = diff * $signed({1'b0, gain});
      sgn = neg ? -prod : prod;
      applyGain = sgn[GAIN_FRAC-RESULT_FRAC +: RESULT_W];
   endfunction : applyGain

   function automatic logic [6:0] calAvgFactor(input logic [1:0] code);
      case (code)
         2'h0: calAvgFactor = 7'h01;
         2'h1: calAvgFactor = 7'h08;
         2'h2: calAvgFactor = 7'h20;
         default: calAvgFactor = 7'h40;
      endcase
   endfunction : calAvgFactor

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic startMeta_r, startSync_r, startOld_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         startMeta_r <= 1'b0;
         startSync_r <= 1'b0;
         startOld_r <= 1'b0;
      end else begin
         startMeta_r <= startPulse;
         startSync_r <= startMeta_r;
         startOld_r <= startSync_r;
      end
   end

   logic startEdge;
   logic initCmd;
   assign startEdge = startSync_r && !startOld_r;
   assign initCmd = commandStrobe && commandCode == OPC_INIT;

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   smseq_state_t state_r, state_nxt;
   logic autoRun_r, autoRun_nxt;
   logic [3:0] cycleCnt_r, cycleCnt_nxt;
   logic calReq_r, calReq_nxt;
   logic [TIME_W-1:0] tA_r, tA_nxt, tB_r, tB_nxt, tRef_r, tRef_nxt;
   logic [TIME_W-1:0] tAB_r, tAB_nxt, tSense_r, tSense_nxt;
   logic bridgeSel_r, bridgeSel_nxt;
   logic signed [TIME_W:0] diffOne_r, diffOne_nxt, diffTwo_r, diffTwo_nxt;
   logic [RESULT_W-1:0] res1_r, res1_nxt, res2_r, res2_nxt;
   logic [TEMP_W-1:0] temp_r, temp_nxt;
   logic [CORR_W-1:0] corrA_r, corrA_nxt, corrB_r, corrB_nxt;
   logic ready_n_r, ready_n_nxt;
   logic disStart_r, disStart_nxt;
   logic [2:0] adaptCnt_r, adaptCnt_nxt;
   logic calBusy;
   logic calDone;

   logic signed [CORR_W:0] corrStep;
   logic [3:0] avgShift;
   logic signed [TIME_W:0] rawDiff;

   always_comb begin
      state_nxt = state_r;
      autoRun_nxt = autoRun_r;
      cycleCnt_nxt = cycleCnt_r;
      calReq_nxt = calReq_r;
      tA_nxt = tA_r;
      tB_nxt = tB_r;
      tAB_nxt = tAB_r;
      tSense_nxt = tSense_r;
      tRef_nxt = tRef_r;
      bridgeSel_nxt = bridgeSel_r;
      diffOne_nxt = diffOne_r;
      diffTwo_nxt = diffTwo_r;
      res1_nxt = res1_r;
      res2_nxt = res2_r;
      temp_nxt = temp_r;
      corrA_nxt = corrA_r;
      corrB_nxt = corrB_r;
      ready_n_nxt = ready_n_r;
      disStart_nxt = 1'b0;
      adaptCnt_nxt = adaptCnt_r;
      corrStep = '0;
      avgShift = 4'h0;
      rawDiff = '0;
      if (serialAccess) begin
         ready_n_nxt = 1'b1;
      end
      if (storedCorrectionLoad) begin
         corrA_nxt = storedSwitchCorrectionA;
         corrB_nxt = storedSwitchCorrectionB;
      end
      if (calDone) begin
         calReq_nxt = 1'b0;
      end
      case (state_r)
         SM_WAIT: begin
            if ((commandStrobe && commandCode == 8'h01) || startEdge || autoRun_r) begin
               autoRun_nxt = !oneShotSelect;
               bridgeSel_nxt = 1'b0;
               disStart_nxt = 1'b1;
               state_nxt = SM_SWITCH_A;
            end
         end
         SM_SWITCH_A: begin
            if (timeValid) begin
               tA_nxt = timeValue;
               disStart_nxt = 1'b1;
               state_nxt = SM_SWITCH_B;
            end
         end
         SM_SWITCH_B: begin
            if (timeValid) begin
               tB_nxt = timeValue;
               disStart_nxt = 1'b1;
               state_nxt = SM_SWITCH_AB;
            end
         end
         SM_SWITCH_AB: begin
            if (timeValid) begin
               tAB_nxt = timeValue;
               if (simplifiedSwitchCompensation) begin
                  corrStep = $signed({1'b0, tA_r[TIME_W-1:1]}) - $signed({1'b0, timeValue});
               end else begin
                  corrStep = $signed({1'b0, tA_r}) + $signed({1'b0, tB_r}) - $signed({1'b0, timeValue, 1'b0});
               end
               avgShift = (adaptCnt_r != 3'h0) ? 4'h0 : switchCorrectionAveraging;
               if (adaptCnt_r != 3'h0) begin
                  adaptCnt_nxt = adaptCnt_r - 3'h1;
               end
               if (!bridgeSel_r) begin
                  corrA_nxt = corrA_r + CORR_W'((corrStep - $signed({1'b0, corrA_r})) >>> avgShift);
               end else begin
                  corrB_nxt = corrB_r + CORR_W'((corrStep - $signed({1'b0, corrB_r})) >>> avgShift);
               end
               rawDiff = $signed({1'b0, tA_r}) - $signed({1'b0, tB_r});
               if (!bridgeSel_r) begin
                  diffOne_nxt = rawDiff;
                  bridgeSel_nxt = 1'b1;
                  disStart_nxt = 1'b1;
                  state_nxt = SM_SWITCH_A;
               end else begin
                  diffTwo_nxt = rawDiff;
                  disStart_nxt = tempEnable;
                  state_nxt = tempEnable ? SM_TEMP_SENSE : SM_FORMAT;
               end
            end
         end
         SM_TEMP_SENSE: begin
            if (timeValid) begin
               tSense_nxt = timeValue;
               disStart_nxt = 1'b1;
               state_nxt = SM_TEMP_REF;
            end
         end
         SM_TEMP_REF: begin
            if (timeValid) begin
               tRef_nxt = timeValue;
               state_nxt = SM_FORMAT;
            end
         end
         SM_FORMAT: begin
            res1_nxt = applyGain(diffOne_r, firstGainFactor, firstGainPolarity);
            res2_nxt = secondGainEnable ? applyGain(diffTwo_r, secondGainFactor, secondGainPolarity)
                                        : applyGain(diffTwo_r, firstGainFactor, firstGainPolarity);
            if (tempEnable && tRef_r != '0) begin
               temp_nxt = TEMP_W'(({tSense_r, {TEMP_FRAC{1'b0}}}) / tRef_r);
            end
            state_nxt = SM_DONE;
         end
         SM_DONE: begin
            ready_n_nxt = 1'b0;
            if (cycleCnt_r + 4'h1 >= calibrationInterval) begin
               cycleCnt_nxt = 4'h0;
               calReq_nxt = 1'b1;
            end else begin
               cycleCnt_nxt = cycleCnt_r + 4'h1;
            end
            autoRun_nxt = autoRun_r && !oneShotSelect;
            state_nxt = SM_WAIT;
         end
         default: state_nxt = SM_WAIT;
      endcase
      if (initCmd) begin
         state_nxt = SM_WAIT;
         autoRun_nxt = 1'b0;
         ready_n_nxt = ready_n_r | serialAccess;
         corrA_nxt = '0;
         corrB_nxt = '0;
         cycleCnt_nxt = 4'h0;
         calReq_nxt = 1'b0;
         adaptCnt_nxt = switchCorrectionAdaptSpeed;
         disStart_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= SM_WAIT;
         autoRun_r <= 1'b0;
         cycleCnt_r <= 4'h0;
         calReq_r <= 1'b0;
         tA_r <= '0;
         tB_r <= '0;
         tAB_r <= '0;
         tSense_r <= '0;
         tRef_r <= '0;
         bridgeSel_r <= 1'b0;
         diffOne_r <= '0;
         diffTwo_r <= '0;
         res1_r <= '0;
         res2_r <= '0;
         temp_r <= '0;
         corrA_r <= '0;
         corrB_r <= '0;
         ready_n_r <= 1'b1;
         disStart_r <= 1'b0;
         adaptCnt_r <= ADAPT_DEF;
      end else begin
         state_r <= state_nxt;
         autoRun_r <= autoRun_nxt;
         cycleCnt_r <= cycleCnt_nxt;
         calReq_r <= calReq_nxt;
         tA_r <= tA_nxt;
         tB_r <= tB_nxt;
         tAB_r <= tAB_nxt;
         tSense_r <= tSense_nxt;
         tRef_r <= tRef_nxt;
         bridgeSel_r <= bridgeSel_nxt;
         diffOne_r <= diffOne_nxt;
         diffTwo_r <= diffTwo_nxt;
         res1_r <= res1_nxt;
         res2_r <= res2_nxt;
         temp_r <= temp_nxt;
         corrA_r <= corrA_nxt;
         corrB_r <= corrB_nxt;
         ready_n_r <= ready_n_nxt;
         disStart_r <= disStart_nxt;
         adaptCnt_r <= adaptCnt_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Calibration
   // -----------------------------------------------------------------
   smseq_cal_timer u_cal (
      .core_clk(core_clk),
      .rst(rst),
      .dischargeStart(disStart_r),
      .calibrationStartDelay(calibrationStartDelay),
      .calEnable(measRangeTwo && calReq_r),
      .calActive(calBusy),
      .calDone(calDone)
   );

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign dischargeStart = disStart_r;
   assign dischargePath = (state_r == SM_SWITCH_A) ? 3'h1 : (state_r == SM_SWITCH_B) ? 3'h2 :
                          (state_r == SM_SWITCH_AB) ? 3'h3 : (state_r == SM_TEMP_SENSE) ? 3'h4 :
                          (state_r == SM_TEMP_REF) ? 3'h5 : 3'h0;
   assign calActive = calBusy;
   assign calAverageCount = calAvgFactor(calibrationAveraging);
   assign bridgeOneResult = res1_r;
   assign bridgeTwoResult = res2_r;
   assign tempRatio = temp_r;
   assign switchCorrectionA = corrA_r;
   assign switchCorrectionB = corrB_r;
   assign busy = state_r != SM_WAIT;
   assign dataReady_n = ready_n_r;

endmodule : strain_measurement_sequencing

// *** bench/smseq_conv_model.sv ***
// Behavioural time converter that answers each discharge with a time value.
module smseq_conv_model
   import smseq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dischargeStart,
   input wire logic [2:0] dischargePath,
   input wire logic [7:0] lagCycles,
   output logic timeValid,
   output logic [TIME_W-1:0] timeValue
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] left;
   logic [TIME_W-1:0] lastVal;

   function automatic logic [TIME_W-1:0] pathTime(input logic [2:0] p);
      case (p)
         3'h1: pathTime = 16'h0120;
         3'h2: pathTime = 16'h0116;
         3'h3: pathTime = 16'h0090;
         3'h4: pathTime = 16'h012C;
         default: pathTime = 16'h00C8;
      endcase
   endfunction : pathTime

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         left <= 8'h00;
         timeValid <= 1'b0;
         lastVal <= 16'h0000;
      end else begin
         timeValid <= 1'b0;
         if (dischargeStart) begin
            left <= lagCycles;
         end else if (left != 8'h00) begin
            left <= left - 8'h01;
            if (left == 8'h01) begin
               timeValid <= 1'b1;
               lastVal <= pathTime(dischargePath);
            end
         end
      end
   end

   // Outside a result the value lines show the inverse of the last value.
   assign timeValue = timeValid ? lastVal : ~lastVal;
endmodule : smseq_conv_model

// *** bench/smseq_check_assertions.sv ***
// Concurrent checks on the sequencer ports.
module smseq_checker
   import smseq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic commandStrobe,
   input wire logic [7:0] commandCode,
   input wire logic serialAccess,
   input wire logic storedCorrectionLoad,
   input wire logic [CORR_W-1:0] storedSwitchCorrectionA,
   input wire logic [3:0] calibrationStartDelay,
   input wire logic [1:0] calibrationAveraging,
   input wire logic timeValid,
   input wire logic dischargeStart,
   input wire logic [2:0] dischargePath,
   input wire logic calActive,
   input wire logic [6:0] calAverageCount,
   input wire logic [RESULT_W-1:0] bridgeOneResult,
   input wire logic [TEMP_W-1:0] tempRatio,
   input wire logic [CORR_W-1:0] switchCorrectionA,
   input wire logic busy,
   input wire logic dataReady_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic initCmd;
   logic [4:0] sinceStart_r;
   logic [4:0] sinceStart_nxt;
   assign initCmd = commandStrobe && commandCode == OPC_INIT;

   // Counts core cycles since the last discharge start, saturating.
   always_comb begin
      sinceStart_nxt = sinceStart_r;
      if (dischargeStart) begin
         sinceStart_nxt = 5'h01;
      end else if (sinceStart_r != 5'h1F) begin
         sinceStart_nxt = sinceStart_r + 5'h01;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sinceStart_r <= 5'h1F;
      end else begin
         sinceStart_r <= sinceStart_nxt;
      end
   end

   property p_readyHold;
      !dataReady_n && !serialAccess && !initCmd |=> !dataReady_n;
   endproperty
   a_readyHold: assert property (p_readyHold) else $error("ready line let go without access");
   property p_readyRelease;
      !dataReady_n && serialAccess |=> dataReady_n;
   endproperty
   a_readyRelease: assert property (p_readyRelease) else $error("ready line kept low after access");
   property p_readyCause;
      $fell(dataReady_n) |-> $past(busy) && !$past(initCmd);
   endproperty
   a_readyCause: assert property (p_readyCause) else $error("ready set without a finished sequence");
   property p_initStop;
      initCmd |=> !busy;
   endproperty
   a_initStop: assert property (p_initStop) else $error("reinit did not stop the sequence");
   property p_startAnswer;
      commandStrobe && commandCode == 8'h01 && !busy |=> dischargeStart && dischargePath == 3'h1;
   endproperty
   a_startAnswer: assert property (p_startAnswer) else $error("start not answered by first discharge");
   property p_bridgeOrder;
      timeValid && (dischargePath == 3'h1 || dischargePath == 3'h2) && !initCmd
         |=> dischargeStart && dischargePath == $past(dischargePath) + 3'h1;
   endproperty
   a_bridgeOrder: assert property (p_bridgeOrder) else $error("switch discharge order broken");
   property p_tempOrder;
      timeValid && dischargePath == 3'h4 && !initCmd |=> dischargeStart && dischargePath == 3'h5;
   endproperty
   a_tempOrder: assert property (p_tempOrder) else $error("reference discharge not after sensing");
   property p_calWindow;
      $rose(calActive) |-> calActive [*4] ##1 !calActive;
   endproperty
   a_calWindow: assert property (p_calWindow) else $error("calibration window not four cycles");
   property p_calDelay;
      $rose(calActive) |-> sinceStart_r == {1'b0, calibrationStartDelay} + 5'h03;
   endproperty
   a_calDelay: assert property (p_calDelay) else $error("calibration start delay wrong");
   property p_calAvg;
      calAverageCount == (calibrationAveraging == 2'h0 ? 7'h01 : calibrationAveraging == 2'h1 ? 7'h08 :
                          calibrationAveraging == 2'h2 ? 7'h20 : 7'h40);
   endproperty
   a_calAvg: assert property (p_calAvg) else $error("calibration averaging count wrong");
   property p_resultHold;
      !busy |=> $stable(bridgeOneResult) && $stable(tempRatio);
   endproperty
   a_resultHold: assert property (p_resultHold) else $error("result changed while waiting");
   property p_storedLoad;
      storedCorrectionLoad && !initCmd && !busy |=> switchCorrectionA == $past(storedSwitchCorrectionA);
   endproperty
   a_storedLoad: assert property (p_storedLoad) else $error("stored correction not taken");
   c_cal: cover property ($rose(calActive));
   c_ready: cover property ($fell(dataReady_n));
   c_init: cover property (initCmd && busy);
endmodule : smseq_checker

bind strain_measurement_sequencing smseq_checker u_check (.core_clk, .rst, .commandStrobe, .commandCode,
   .serialAccess, .storedCorrectionLoad, .storedSwitchCorrectionA, .calibrationStartDelay, .calibrationAveraging,
   .timeValid, .dischargeStart, .dischargePath, .calActive, .calAverageCount, .bridgeOneResult, .tempRatio,
   .switchCorrectionA, .busy, .dataReady_n);

// *** bench/testbench.sv ***
// Self-checking bench for the strain measurement sequencer.
module testbench
   import smseq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0, rst = 1'b1, startPulse = 1'b0, commandStrobe = 1'b0, serialAccess = 1'b0;
   logic oneShotSelect = 1'b1, measRangeTwo = 1'b1, tempEnable = 1'b1, storedCorrectionLoad = 1'b0;
   logic [7:0] commandCode = 8'h00, lagCycles = 8'h10;
   logic [GAIN_W-1:0] firstGainFactor = 24'h010000, secondGainFactor = 24'h020000;
   logic firstGainPolarity = 1'b0, secondGainPolarity = 1'b1, secondGainEnable = 1'b1;
   logic [3:0] calibrationStartDelay = CAL_DELAY_DEF, calibrationInterval = 4'h1, switchCorrectionAveraging = 4'h2;
   logic [1:0] calibrationAveraging = CAL_AVG_DEF;
   logic [2:0] switchCorrectionAdaptSpeed = ADAPT_DEF;
   logic simplifiedSwitchCompensation = 1'b0, timeValid, dischargeStart, calActive, busy, dataReady_n;
   logic [CORR_W-1:0] storedSwitchCorrectionA = 24'h000000, storedSwitchCorrectionB = 24'h000000;
   logic [CORR_W-1:0] switchCorrectionA, switchCorrectionB;
   logic [TIME_W-1:0] timeValue;
   logic [2:0] dischargePath;
   logic [6:0] calAverageCount;
   logic [RESULT_W-1:0] bridgeOneResult, bridgeTwoResult;
   logic [TEMP_W-1:0] tempRatio;
   int errTotal = 0;
   int cmpCount = 0;

   always #2 core_clk = ~core_clk;

   strain_measurement_sequencing dut (.core_clk, .rst, .startPulse, .commandStrobe, .commandCode, .serialAccess,
      .oneShotSelect, .measRangeTwo, .tempEnable, .firstGainFactor, .secondGainFactor, .firstGainPolarity,
      .secondGainPolarity, .secondGainEnable, .calibrationStartDelay, .calibrationInterval, .calibrationAveraging,
      .switchCorrectionAveraging, .switchCorrectionAdaptSpeed, .simplifiedSwitchCompensation, .storedCorrectionLoad,
      .storedSwitchCorrectionA, .storedSwitchCorrectionB, .timeValid, .timeValue, .dischargeStart, .dischargePath,
      .calActive, .calAverageCount, .bridgeOneResult, .bridgeTwoResult, .tempRatio, .switchCorrectionA,
      .switchCorrectionB, .busy, .dataReady_n);
   smseq_conv_model conv (.core_clk, .rst, .dischargeStart, .dischargePath, .lagCycles, .timeValid, .timeValue);

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkBit(input logic got, input logic exp);
      chk({23'h0, got}, {23'h0, exp});
   endtask : chkBit
   task automatic summarize();
      $display("compares=%0d mismatches=%0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   task automatic cmd(input logic [7:0] code);
      @(posedge core_clk);
      commandStrobe <= 1'b1;
      commandCode <= code;
      @(posedge core_clk);
      commandStrobe <= 1'b0;
   endtask : cmd
   // Waits for the ready line or the given path; running out ends the run.
   task automatic waitFor(input logic onPath, input logic [2:0] path);
      int n;
      n = 0;
      while ((onPath ? dischargePath !== path : dataReady_n !== 1'b0) && n < 3000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 3000) begin
         chkBit(1'b1, 1'b0);
         summarize();
      end
   endtask : waitFor
   task automatic ack();
      @(posedge core_clk);
      serialAccess <= 1'b1;
      @(posedge core_clk);
      serialAccess <= 1'b0;
      @(posedge core_clk);
      #1;
      chkBit(dataReady_n, 1'b1);
   endtask : ack
   task automatic measure(input logic [23:0] e1, input logic [23:0] e2);
      cmd(8'h01);
      waitFor(1'b0, 3'h0);
      chk(bridgeOneResult, e1);
      chk(bridgeTwoResult, e2);
      chk({8'h00, tempRatio}, 24'h006000);
      chkBit(busy, 1'b0);
      ack();
   endtask : measure

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_gains();
      logic [49:0] tab [3];
      tab = '{{1'b0, 1'b1, 24'h000A00, 24'hFFEC00}, {1'b1, 1'b1, 24'hFFF600, 24'hFFEC00},
              {1'b0, 1'b0, 24'h000A00, 24'h000A00}};
      foreach (tab[i]) begin
         @(posedge core_clk);
         firstGainPolarity <= tab[i][49];
         secondGainEnable <= tab[i][48];
         measure(tab[i][47:24], tab[i][23:0]);
      end
      $display("test gains done");
   endtask : t_gains
   task automatic t_prompt();
      @(posedge core_clk);
      measRangeTwo <= 1'b0;
      lagCycles <= 8'h01;
      measure(24'h000A00, 24'h000A00);
      @(posedge core_clk);
      measRangeTwo <= 1'b1;
      lagCycles <= 8'h10;
      $display("test prompt done");
   endtask : t_prompt
   task automatic t_reinit();
      logic seen;
      seen = 1'b0;
      cmd(8'h01);
      waitFor(1'b1, 3'h4);
      cmd(OPC_INIT);
      repeat (60) begin
         @(posedge core_clk);
         #1;
         seen = seen | !dataReady_n;
      end
      chkBit(seen, 1'b0);
      chkBit(busy, 1'b0);
      chk(switchCorrectionA, 24'h000000);
      measure(24'h000A00, 24'h000A00);
      chk(switchCorrectionA, 24'h000116);
      @(posedge core_clk);
      simplifiedSwitchCompensation <= 1'b1;
      measure(24'h000A00, 24'h000A00);
      chk(switchCorrectionA, 24'h000000);
      @(posedge core_clk);
      simplifiedSwitchCompensation <= 1'b0;
      $display("test reinit done");
   endtask : t_reinit
   task automatic t_stored();
      @(posedge core_clk);
      storedCorrectionLoad <= 1'b1;
      storedSwitchCorrectionA <= 24'h00ABCD;
      storedSwitchCorrectionB <= 24'h001234;
      @(posedge core_clk);
      storedCorrectionLoad <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(switchCorrectionA, 24'h00ABCD);
      chk(switchCorrectionB, 24'h001234);
      $display("test stored done");
   endtask : t_stored
   task automatic t_calAvg();
      logic [6:0] exp [4];
      exp = '{7'h01, 7'h08, 7'h20, 7'h40};
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         calibrationAveraging <= 2'(i);
         @(posedge core_clk);
         #1;
         chk({17'h0, calAverageCount}, {17'h0, exp[i]});
      end
      $display("test calAvg done");
   endtask : t_calAvg
   task automatic t_startPin();
      @(posedge core_clk);
      startPulse <= 1'b1;
      repeat (6) @(posedge core_clk);
      startPulse <= 1'b0;
      waitFor(1'b0, 3'h0);
      chk(bridgeOneResult, 24'h000A00);
      ack();
      $display("test startPin done");
   endtask : t_startPin
   task automatic t_auto();
      @(posedge core_clk);
      oneShotSelect <= 1'b0;
      measure(24'h000A00, 24'h000A00);
      repeat (4) @(posedge core_clk);
      #1;
      chkBit(busy, 1'b1);
      @(posedge core_clk);
      oneShotSelect <= 1'b1;
      waitFor(1'b0, 3'h0);
      repeat (4) @(posedge core_clk);
      #1;
      chkBit(busy, 1'b0);
      ack();
      $display("test auto done");
   endtask : t_auto

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(bridgeOneResult, 24'h000000);
      chkBit(dataReady_n, 1'b1);
      t_gains();
      t_prompt();
      t_reinit();
      t_stored();
      t_calAvg();
      t_startPin();
      t_auto();
      summarize();
   end
endmodule : testbench
